// File: core/dist_pkg.sv
// Constants and carrier types for the harmonic distortion alarm monitor.
// Assumes a 50 MHz clock and a front end refreshing ratios every 5 ms.
// Notes on behaviour
// - Blocking sampled once at each processing cycle
// - Unblocked pick-up asserts start, starts delay timer
// - Blocked pick-up shows blocked, no timing, no alarm
// - Blocking during start clears start, shows blocked
// - Definite-time delays per group, 5 ms steps
// - Status reads normal, start, alarm or blocked
// - ON and OFF events for start, alarm, blocked
// - Events time-stamped; storage filter ON, OFF, both
// - Start, alarm, blocked counters, clearable by software
// - Twelve-entry history of ON occurrences with data
// - Release below 97 percent of threshold
// - Phase group picks on any phase; per-group enable
// - One setting selects amplitude or power ratio
// - Ratios cover harmonics to 31, 5 ms refresh
`default_nettype none

package dist_pkg;

    localparam int CLK_MHZ         = 50;
    localparam int PROC_CYCLE_US   = 5000;
    localparam int PROC_CYCLE_CLKS = PROC_CYCLE_US * CLK_MHZ;
    localparam int MS_US           = 1000;
    localparam int MS_CLKS         = MS_US * CLK_MHZ;
    localparam int RESET_PCT       = 97;
    localparam int FULL_PCT        = 100;
    localparam int HIST_DEPTH      = 12;
    localparam int CHANNELS        = 5;
    localparam int GROUPS          = 3;

    // Threshold in 0.01 %, delay in 5 ms steps
    localparam logic [13:0] THR_RST   = 14'h03E8;
    localparam logic [18:0] DELAY_RST = 19'h007D0;
    localparam logic [2:0]  EN_RST    = 3'h7;

    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_THR0   = 5'h01;
    localparam logic [4:0] REG_DLY0   = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h07;
    localparam logic [4:0] REG_CNT0   = 5'h08;
    localparam logic [4:0] REG_HSEL   = 5'h0B;
    localparam logic [4:0] REG_HTIME  = 5'h0C;
    localparam logic [4:0] REG_HINFO  = 5'h0D;
    localparam logic [4:0] REG_HL12   = 5'h0E;
    localparam logic [4:0] REG_HL3    = 5'h0F;
    localparam logic [4:0] REG_TIME   = 5'h10;

    localparam int CTRL_METHOD = 0;
    localparam int CTRL_FILT   = 1;
    localparam int CTRL_EN     = 3;
    localparam int CTRL_CLR    = 8;

    typedef enum logic [1:0] {
        FILT_BOTH = 2'h0,
        FILT_ON   = 2'h1,
        FILT_OFF  = 2'h2
    } filt_t;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'h0,
        ST_START   = 2'h1,
        ST_ALARM   = 2'h3,
        ST_BLOCKED = 2'h2
    } status_t;

    typedef struct packed {
        logic [15:0] amp;
        logic [15:0] pow;
    } ratio_pair_t;

    typedef struct packed {
        logic        valid;
        logic        store;
        logic        on;
        logic [3:0]  id;
        logic [31:0] stamp;
    } event_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [3:0]  id;
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
        logic [2:0]  group;
    } hist_t;

endpackage : dist_pkg

`default_nettype wire

// File: core/distortion_channel.sv
// One supervised channel group: pick-up with hysteresis and definite-time alarm.
// Assumes go pulses once per processing cycle with blk and ratio already frozen.
`default_nettype none

module distortion_channel (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Processing cycle inputs
    input  wire logic              go,
    input  wire logic              enable,
    input  wire logic              blk,
    input  wire logic [13:0]       thr,
    input  wire logic [15:0]       ratio,
    input  wire logic [18:0]       delay,
    // State
    output var  dist_pkg::status_t status
);
    import dist_pkg::*;

    typedef struct packed {
        status_t     st;
        logic        picked;
        logic [18:0] cnt;
    } chan_t;

    chan_t       s;
    chan_t       n;
    logic        pick_n;
    logic [23:0] r100;
    logic [23:0] t97;

    always_comb
    begin
        n = s;
        r100 = 24'(ratio) * 24'(FULL_PCT);
        t97 = 24'(thr) * 24'(RESET_PCT);
        pick_n = enable && (s.picked ? (r100 >= t97) : (ratio > 16'(thr)));
        if (go)
        begin
            n.picked = pick_n;
            case (s.st)
                ST_NORMAL:
                    if (pick_n)
                    begin
                        n.st = blk ? ST_BLOCKED : ST_START;
                        n.cnt = delay;
                    end
                ST_START:
                    if (!pick_n)
                        n.st = ST_NORMAL;
                    else if (blk)
                        n.st = ST_BLOCKED;
                    else if (s.cnt == 19'h0)
                        n.st = ST_ALARM;
                    else
                        n.cnt = s.cnt - 19'h1;
                ST_ALARM:
                    if (!pick_n)
                        n.st = ST_NORMAL;
                    else if (blk)
                        n.st = ST_BLOCKED;
                // Blocked holds until the pick-up itself goes away
                ST_BLOCKED:
                    if (!pick_n)
                        n.st = ST_NORMAL;
                default:
                    n.st = ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign status = s.st;

endmodule : distortion_channel

`default_nettype wire

// File: core/harmonic_distortion_alarm_monitor.sv
// Harmonic distortion alarm supervisor: three groups, events, counters, history.
// Assumes ratios come on this clock; block_in is asynchronous to it.
`default_nettype none

module harmonic_distortion_alarm_monitor #(
    parameter int CYCLE_CLKS = dist_pkg::PROC_CYCLE_CLKS,
    parameter int MS_CLKS    = dist_pkg::MS_CLKS
) (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst,
    // Measurement front end, same clock
    input  wire dist_pkg::ratio_pair_t [4:0]    ratios,
    input  wire logic [2:0]                     setting_group,
    // Blocking matrix pin
    input  wire logic                           block_in,
    // Register port
    input  wire logic [4:0]                     addr,
    input  wire logic [31:0]                    wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output var  logic [31:0]                    rdata,
    // Supervision outputs
    output var  logic [2:0]                     start_out,
    output var  logic [2:0]                     alarm_out,
    output var  logic                           blocked_out,
    output var  dist_pkg::status_t              status,
    output var  dist_pkg::event_t               event_out
);
    import dist_pkg::*;

    typedef struct packed {
        logic [1:0]                   blk_sync;
        logic                         blk;
        logic                         go;
        logic [31:0]                  div;
        logic [31:0]                  ms_div;
        logic [31:0]                  ms;
        logic                         method;
        filt_t                        filt;
        logic [2:0]                   en;
        logic [2:0][13:0]             thr;
        logic [2:0][18:0]             delay;
        logic [4:0][15:0]             ratio;
        logic [6:0]                   prev;
        logic [13:0]                  pend;
        event_t                       ev;
        logic [2:0][15:0]             cnt;
        logic [3:0]                   hsel;
        logic [3:0]                   hwr;
        logic [3:0]                   hcnt;
        hist_t [HIST_DEPTH-1:0]       hist;
        logic [31:0]                  rdata;
    } state_t;

    state_t            s;
    state_t            n;
    status_t [2:0]     ch_st;
    logic [2:0][15:0]  grp_ratio;
    logic [6:0]        src;
    logic [13:0]       fresh;
    logic [13:0]       taken;
    logic [3:0]        pick;
    logic [2:0]        ev_src;
    logic              ev_on;
    logic [1:0]        cls;
    logic              clr;
    logic [4:0]        hidx;
    hist_t             h;
    logic [31:0]       rv;

    // Phase group follows the worst phase
    always_comb
    begin
        grp_ratio[0] = s.ratio[0];
        if (s.ratio[1] > grp_ratio[0])
            grp_ratio[0] = s.ratio[1];
        if (s.ratio[2] > grp_ratio[0])
            grp_ratio[0] = s.ratio[2];
        grp_ratio[1] = s.ratio[3];
        grp_ratio[2] = s.ratio[4];
    end

    for (genvar g = 0; g < GROUPS; g++)
    begin : gen_group
        distortion_channel u_channel (
            .clock  (clock),
            .rst    (rst),
            .go     (s.go),
            .enable (s.en[g]),
            .blk    (s.blk),
            .thr    (s.thr[g]),
            .ratio  (grp_ratio[g]),
            .delay  (s.delay[g]),
            .status (ch_st[g])
        );
        assign start_out[g] = (ch_st[g] == ST_START);
        assign alarm_out[g] = (ch_st[g] == ST_ALARM);
    end

    assign blocked_out = (ch_st[0] == ST_BLOCKED) || (ch_st[1] == ST_BLOCKED)
                       || (ch_st[2] == ST_BLOCKED);

    // Worst state across groups wins
    always_comb
    begin
        if (blocked_out)
            status = ST_BLOCKED;
        else if (alarm_out != 3'h0)
            status = ST_ALARM;
        else if (start_out != 3'h0)
            status = ST_START;
        else
            status = ST_NORMAL;
    end

    assign src = {blocked_out, alarm_out, start_out};
    assign clr = wr && (addr == REG_CTRL) && wdata[CTRL_CLR];

    // Event encoding: id = 2 * source + off
    always_comb
    begin
        fresh = '0;
        for (int i = 0; i < 7; i++)
        begin
            if (src[i] != s.prev[i])
            begin
                fresh[2*i] = src[i];
                fresh[2*i+1] = !src[i];
            end
        end
        pick = 4'h0;
        for (int i = 13; i >= 0; i--)
        begin
            if (s.pend[i])
                pick = 4'(i);
        end
        taken = (s.pend != 14'h0) ? (14'h1 << pick) : 14'h0;
        ev_src = pick[3:1];
        ev_on = !pick[0];
        if (ev_src < 3'h3)
            cls = 2'h0;
        else if (ev_src < 3'h6)
            cls = 2'h1;
        else
            cls = 2'h2;
    end

    // Newest history entry is selection 0
    always_comb
    begin
        hidx = 5'(s.hwr) + 5'(HIST_DEPTH) - 5'h1 - 5'(s.hsel);
        if (hidx >= 5'(HIST_DEPTH))
            hidx = hidx - 5'(HIST_DEPTH);
        h = s.hist[hidx[3:0]];
    end

    always_comb
    begin
        rv = 32'h0;
        case (addr)
            REG_CTRL:
                rv = {26'h0, s.en, s.filt, s.method};
            REG_STATUS:
                rv = {23'h0, s.blk, ch_st[2], ch_st[1], ch_st[0], status};
            REG_HSEL:
                rv = {24'h0, s.hcnt, s.hsel};
            REG_HTIME:
                rv = h.stamp;
            REG_HINFO:
                rv = {25'h0, h.group, h.id};
            REG_HL12:
                rv = {h.l2, h.l1};
            REG_HL3:
                rv = {16'h0, h.l3};
            REG_TIME:
                rv = s.ms;
            default:
                for (int i = 0; i < GROUPS; i++)
                begin
                    if (addr == REG_THR0 + 5'(i))
                        rv = {18'h0, s.thr[i]};
                    if (addr == REG_DLY0 + 5'(i))
                        rv = {13'h0, s.delay[i]};
                    if (addr == REG_CNT0 + 5'(i))
                        rv = {16'h0, s.cnt[i]};
                end
        endcase
    end

    always_comb
    begin
        n = s;
        n.blk_sync = {s.blk_sync[0], block_in};
        n.rdata = rd ? rv : 32'h0;

        // Processing cycle: freeze block and ratios for the whole cycle
        n.go = 1'b0;
        n.div = s.div + 32'h1;
        if (s.div == 32'(CYCLE_CLKS - 1))
        begin
            n.div = 32'h0;
            n.go = 1'b1;
            // Late block may miss a delay ending this cycle
            n.blk = s.blk_sync[1];
            for (int i = 0; i < CHANNELS; i++)
            begin
                n.ratio[i] = s.method ? ratios[i].pow : ratios[i].amp;
            end
        end

        // Millisecond time base for stamps
        n.ms_div = s.ms_div + 32'h1;
        if (s.ms_div == 32'(MS_CLKS - 1))
        begin
            n.ms_div = 32'h0;
            n.ms = s.ms + 32'h1;
        end

        if (wr)
        begin
            case (addr)
                REG_CTRL:
                begin
                    n.method = wdata[CTRL_METHOD];
                    n.filt = filt_t'(wdata[CTRL_FILT +: 2]);
                    n.en = wdata[CTRL_EN +: 3];
                end
                REG_HSEL:
                    if (wdata[3:0] < 4'(HIST_DEPTH))
                        n.hsel = wdata[3:0];
                default:
                    for (int i = 0; i < GROUPS; i++)
                    begin
                        if (addr == REG_THR0 + 5'(i))
                            n.thr[i] = wdata[13:0];
                        if (addr == REG_DLY0 + 5'(i))
                            n.delay[i] = wdata[18:0];
                    end
            endcase
        end

        // One event per clock; a change seen now is never lost
        n.prev = src;
        n.pend = (s.pend & ~taken) | fresh;
        n.ev.valid = (s.pend != 14'h0);
        n.ev.id = pick;
        n.ev.on = ev_on;
        n.ev.stamp = s.ms;
        case (s.filt)
            FILT_ON:
                n.ev.store = ev_on;
            FILT_OFF:
                n.ev.store = !ev_on;
            default:
                n.ev.store = 1'b1;
        endcase

        // Counters: an occurrence beside a clear still counts
        for (int k = 0; k < GROUPS; k++)
        begin
            n.cnt[k] = clr ? 16'h0 : s.cnt[k];
            if ((s.pend != 14'h0) && ev_on && (cls == 2'(k)))
                n.cnt[k] = n.cnt[k] + 16'h1;
        end

        // History keeps ON occurrences only, oldest overwritten
        if ((s.pend != 14'h0) && ev_on)
        begin
            n.hist[s.hwr].stamp = s.ms;
            n.hist[s.hwr].id = pick;
            n.hist[s.hwr].l1 = s.ratio[0];
            n.hist[s.hwr].l2 = s.ratio[1];
            n.hist[s.hwr].l3 = s.ratio[2];
            n.hist[s.hwr].group = setting_group;
            if (s.hwr == 4'(HIST_DEPTH - 1))
                n.hwr = 4'h0;
            else
                n.hwr = s.hwr + 4'h1;
            if (s.hcnt != 4'(HIST_DEPTH))
                n.hcnt = s.hcnt + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.en <= EN_RST;
            s.thr <= {GROUPS{THR_RST}};
            s.delay <= {GROUPS{DELAY_RST}};
        end
        else
        begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign event_out = s.ev;

endmodule : harmonic_distortion_alarm_monitor

`default_nettype wire

// File: verification/distortion_monitor.sv
// Concurrent checks on the alarm monitor's outputs.
// Assumes a processing cycle of at least ten clocks.
`default_nettype none

module distortion_monitor
    import dist_pkg::*;
(
    // Clock and reset
    input wire logic           clock,
    input wire logic           rst,
    // Register port
    input wire logic           rd,
    input wire logic [31:0]    rdata,
    // Supervision outputs
    input wire logic [2:0]     start_out,
    input wire logic [2:0]     alarm_out,
    input wire logic           blocked_out,
    input wire dist_pkg::status_t status,
    input wire dist_pkg::event_t  event_out
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_STATUS_BLK: assert property (blocked_out |-> status == ST_BLOCKED)
        else $error("blocked status missing");
    AST_STATUS_ALM: assert property (!blocked_out && |alarm_out |-> status == ST_ALARM)
        else $error("alarm status missing");
    AST_STATUS_LOW: assert property (!blocked_out && alarm_out == 3'h0
        |-> status == (|start_out ? ST_START : ST_NORMAL))
        else $error("start or normal status wrong");
    AST_START_EVT: assert property ($rose(start_out[0])
        |-> ##2 (event_out.valid && event_out.on && event_out.id == 4'h0))
        else $error("start on event missing");
    AST_ALM_OFF_EVT: assert property ($fell(alarm_out[0])
        |-> ##[1:8] (event_out.valid && !event_out.on && event_out.id == 4'h7))
        else $error("alarm off event missing");
    AST_BLK_EVT: assert property ($rose(blocked_out)
        |-> ##[1:8] (event_out.valid && event_out.on && event_out.id == 4'hC))
        else $error("blocked on event missing");
    AST_STATE_HOLD: assert property ($changed(start_out) |=> $stable(start_out)[*8])
        else $error("start changed inside a cycle");
    AST_ALM_AFTER_START: assert property ($rose(alarm_out[0]) |-> $past(start_out[0]))
        else $error("alarm without timing");
    AST_EVT_ON_BIT: assert property (event_out.valid |-> event_out.on == !event_out.id[0])
        else $error("event on bit wrong");
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
endmodule : distortion_monitor

`default_nettype wire

// File: verification/front_end_model.sv
// Model of the measurement front end and the blocking matrix.
// Assumes the bench sets wanted values; ratios reach the pins on a refresh tick.
`default_nettype none

module front_end_model
    import dist_pkg::*;
#(
    parameter int REFRESH = 20
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // Bench side
    input  wire dist_pkg::ratio_pair_t [4:0] want,
    input  wire logic                     block_want,
    // Monitor side
    output var  dist_pkg::ratio_pair_t [4:0] ratios,
    output var  logic                     block_in
);
    int tick;

    // New sets appear only on the refresh base, never mid-way
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tick   <= 0;
            ratios <= '0;
        end
        else
        begin
            tick <= (tick == REFRESH - 1) ? 0 : tick + 1;
            if (tick == 0)
                ratios <= want;
        end
    end

    // Bench raises the level cycles ahead of any expiry
    assign block_in = block_want;
endmodule : front_end_model

`default_nettype wire

// File: verification/harmonic_distortion_alarm_monitor_tb.sv
// Self-checking bench for the distortion alarm monitor.
// Assumes the short processing cycle set below and the front end model.
`default_nettype none

module harmonic_distortion_alarm_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dist_pkg::*;

    localparam int CYC = 20;
    logic              clock, rst, wr, rd, block_want, block_in, blocked_out, exp1;
    logic [4:0]        addr;
    logic [31:0]       wdata, rdata, lfsr;
    logic [2:0]        setting_group, start_out, alarm_out;
    logic [1:0]        filt;
    status_t           status;
    event_t            event_out;
    ratio_pair_t [4:0] want, ratios;
    int                err_total, num_checks, n, i;

    front_end_model #(.REFRESH(CYC)) u_front_end_model (.clock(clock), .rst(rst),
        .want(want), .block_want(block_want), .ratios(ratios), .block_in(block_in));

    harmonic_distortion_alarm_monitor #(.CYCLE_CLKS(CYC), .MS_CLKS(4))
        u_harmonic_distortion_alarm_monitor (.clock(clock), .rst(rst), .ratios(ratios),
        .setting_group(setting_group), .block_in(block_in), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .start_out(start_out), .alarm_out(alarm_out),
        .blocked_out(blocked_out), .status(status), .event_out(event_out));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Pick-up above threshold, release under 97 percent of it
    function automatic logic keep(input int r, input logic prev);
        return prev ? (r * 100 >= 1000 * 97) : (r > 1000);
    endfunction : keep

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : check

    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wreg

    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 check(nm, e, rdata & m);
        @(posedge clock);
    endtask : rchk

    task automatic waitp(input int k);
        repeat (k * CYC) @(posedge clock);
    endtask : waitp

    // Counts negedges until the level shows; bounded
    task automatic await(input int g, input bit alm, input bit lvl, output int c);
        c = 0;
        do
        begin
            @(negedge clock);
            c++;
        end
        while (((alm ? alarm_out[g] : start_out[g]) !== lvl) && c < 2000);
        check("await", 1, c < 2000);
        @(posedge clock);
    endtask : await

    task automatic report_and_stop;
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    always @(negedge clock)
        if (event_out.valid === 1'b1)
            check("store", filt == FILT_BOTH || (filt == FILT_ON) == event_out.on, event_out.store);

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        rst = 1'b1;
        {wr, rd, block_want, exp1} = 4'h0;
        addr = 5'h00;
        wdata = 32'h0;
        want = '0;
        setting_group = 3'h0;
        filt = FILT_BOTH;
        lfsr = 32'h994CA68E;
        err_total = 0;
        num_checks = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk("ctrl", REG_CTRL, 32'h3F, 32'h38);
        rchk("delay", REG_DLY0, 32'h7FFFF, 32'h7D0);
        rchk("thr", REG_THR0, 32'h3FFF, 32'h3E8);
        rchk("unmapped", 5'h1F, 32'hFFFFFFFF, 32'h0);
        // Two steps of delay; one phase alone over threshold
        wreg(REG_DLY0, 32'h2);
        setting_group <= 3'h5;
        want[1].amp <= 16'h04B0;
        await(0, 0, 1, n);
        await(0, 1, 1, n);
        check("alarm delay", 32'd60, 32'(n));
        check("status", ST_ALARM, status);
        want[1].amp <= 16'h03D4;
        waitp(3);
        check("hysteresis", 1, alarm_out[0]);
        want[1].amp <= 16'h03C0;
        await(0, 1, 0, n);
        rchk("hist count", REG_HSEL, 32'hF0, 32'h20);
        rchk("hist info", REG_HINFO, 32'h7F, 32'h56);
        rchk("hist l12", REG_HL12, 32'hFFFFFFFF, 32'h04B00000);
        rchk("cnt start", REG_CNT0, 32'hFFFF, 32'h1);
        wreg(REG_CTRL, 32'h138);
        rchk("cnt clear", REG_CNT0, 32'hFFFF, 32'h0);
        // Pick-up lost before expiry
        want[1].amp <= 16'h04B0;
        await(0, 0, 1, n);
        want[1].amp <= 16'h0000;
        await(0, 0, 0, n);
        waitp(3);
        rchk("cnt alarm", REG_CNT0 + 5'h1, 32'hFFFF, 32'h0);
        // Blocked before pick-up, ON events filtered out
        filt = FILT_OFF;
        wreg(REG_CTRL, 32'h3C);
        block_want <= 1'b1;
        waitp(2);
        want[0].amp <= 16'h04B0;
        waitp(3);
        check("blocked", 1, blocked_out);
        check("blk status", ST_BLOCKED, status);
        check("blk start", 3'h0, start_out);
        want[0].amp <= 16'h0000;
        block_want <= 1'b0;
        waitp(3);
        rchk("cnt blocked", REG_CNT0 + 5'h2, 32'hFFFF, 32'h1);
        // Blocking arrives while timing runs
        filt = FILT_ON;
        wreg(REG_CTRL, 32'h3A);
        want[2].amp <= 16'h04B0;
        await(0, 0, 1, n);
        block_want <= 1'b1;
        waitp(3);
        check("blk clears", 3'h0, start_out | alarm_out);
        want[2].amp <= 16'h0000;
        block_want <= 1'b0;
        waitp(3);
        // Phase group disabled
        filt = FILT_BOTH;
        wreg(REG_CTRL, 32'h30);
        want[0].amp <= 16'h07D0;
        waitp(4);
        check("disabled", 1'b0, start_out[0]);
        want[0].amp <= 16'h0000;
        // Power ratio selects the other field
        wreg(REG_CTRL, 32'h39);
        want[2].pow <= 16'h05DC;
        await(0, 0, 1, n);
        want[2].pow <= 16'h0000;
        wreg(REG_CTRL, 32'h38);
        waitp(3);
        // Residual one around its threshold
        for (i = 0; i < 30; i++)
        begin
            lfsr = lfsr_next(lfsr);
            want[3].amp <= 16'd900 + 16'(lfsr[7:0]);
            setting_group <= lfsr[10:8];
            exp1 = keep(900 + int'(lfsr[7:0]), exp1);
            waitp(3);
            check("res1", exp1, start_out[1] | alarm_out[1]);
        end
        report_and_stop();
    end
endmodule : harmonic_distortion_alarm_monitor_tb

bind harmonic_distortion_alarm_monitor distortion_monitor u_distortion_monitor (
    .clock(clock), .rst(rst), .rd(rd), .rdata(rdata), .start_out(start_out),
    .alarm_out(alarm_out), .blocked_out(blocked_out), .status(status),
    .event_out(event_out));

`default_nettype wire
